// >>> dcc_defs.svh
/*
 * Register offsets, field positions, reset values and sizes for the dual
 * comparator control block.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// apb byte offsets, one aligned word per register
`define DCC_ADDR_W        12
`define DCC_OFS_CMP_A     12'h000
`define DCC_OFS_CMP_B     12'h004
`define DCC_OFS_AUX       12'h008
`define DCC_OFS_IRQ_EN    12'h00c
`define DCC_OFS_IRQ_FLAG  12'h010
`define DCC_OFS_PORT      12'h014
`define DCC_OFS_ANALOG    12'h018
`define DCC_OFS_DIR       12'h01c

// per-comparator control field positions
`define DCC_CTL_EN        7
`define DCC_CTL_RESULT    6
`define DCC_CTL_DRIVE     5
`define DCC_CTL_INVERT    4
`define DCC_CTL_REF       2
`define DCC_CTL_CH_HI     1
`define DCC_CTL_CH_LO     0

// auxiliary register field positions
`define DCC_AUX_COPY_A    7
`define DCC_AUX_COPY_B    6
`define DCC_AUX_GSS       1
`define DCC_AUX_SYNC      0

// interrupt enable register field positions
`define DCC_IE_A          0
`define DCC_IE_B          1
`define DCC_IE_PERIPH     2
`define DCC_IE_GLOBAL     3

// reset values
`define DCC_RST_CTL       6'h00
`define DCC_RST_GSS       1'b1
`define DCC_RST_SYNC      1'b0
`define DCC_RST_DIR       8'hff

// input synchroniser depth
`define DCC_SYNC_STAGES   3

`endif

// >>> dcc_pkg.sv
/*
 * Types shared by the dual comparator control block.
 * Assumes dcc_defs.svh is on the include path.
 */
`include "dcc_defs.svh"

package dcc_pkg;

	// stored fields of one comparator control register
	typedef struct packed {
		logic       enable;
		logic       pin_drive;
		logic       invert;
		logic       ref_select;
		logic [1:0] channel_select;
	} dcc_ctl_t;

	// decoded register selection
	typedef enum logic [3:0] {
		DCC_SEL_CMP_A,
		DCC_SEL_CMP_B,
		DCC_SEL_AUX,
		DCC_SEL_IRQ_EN,
		DCC_SEL_IRQ_FLAG,
		DCC_SEL_PORT,
		DCC_SEL_ANALOG,
		DCC_SEL_DIR,
		DCC_SEL_NONE
	} dcc_sel_t;

	// settings handed to one analog comparator
	typedef struct packed {
		logic       enable;
		logic       ref_select;
		logic [1:0] channel_select;
	} dcc_analog_t;

endpackage : dcc_pkg

// >>> dcc_top.sv
/*
 * Dual comparator control: apb register file, result polarity, pin drive,
 * mismatch interrupt flags, wake request, timer gate source and capture.
 * Assumes analog comparators, timer and core sit outside; comparator
 * results, timer clock, gate pin and port pins arrive asynchronously.
 */
`timescale 1ns/1ps
`include "dcc_defs.svh"

// Contract
// - an enabled comparator keeps running and updating during sleep
// - output change wakes device when its enable and peripheral enable set
// - after wake the next instruction runs; vector only with global enable
// - any reset returns all three control registers to reset values
// - bit 7 enables the comparator when set
// - bit 6 reads result, high when plus exceeds minus, inverted by polarity
// - bit 4 inverts the comparator logic output
// - bit 5 routes the result to its pin, else internal only
// - pin driven only with drive, enable set and direction output
// - bit 2 picks internal reference or positive pin for plus input
// - bits 1-0 pick one of four shared minus pins
// - bit 3 of control registers reads zero
// - gate source bit picks synced comparator b or gate pin; resets to 1
// - sync bit set captures comparator b on timer clock falling edge
// - capture uses prescaled timer clock; timer counts on rising edge
// - auxiliary bits 7 and 6 are live copies of both results
// - reading the auxiliary register leaves mismatch latches alone
// - auxiliary bits 5 to 2 read zero
// - port read returns zero for pins set as analog inputs
// - flag set on rising mismatch of read latch and per-cycle latch
// - any write to a control register also clears the mismatch
module dcc_top
	import dcc_pkg::*;
#(
	parameter int PORT_W = 8
) (
	// clock, reset, enable
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`DCC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic [31:0]                prdata,
	// analog comparators
	input  wire logic                  cmp_a_raw,
	input  wire logic                  cmp_b_raw,
	output dcc_analog_t                cmp_a_analog,
	output dcc_analog_t                cmp_b_analog,
	// comparator output pins
	output logic                       cmp_a_pin_out,
	output logic                       cmp_a_pin_oe,
	output logic                       cmp_b_pin_out,
	output logic                       cmp_b_pin_oe,
	// timer
	input  wire logic                  timer_prescaled_clk,
	input  wire logic                  external_gate_pin,
	output logic                       timer_gate,
	// port pins
	input  wire logic [PORT_W-1:0]     port_pins,
	// core
	output logic                       wake_req,
	output logic                       irq_vector
);

	////////////////////////////////////////////////////////////////////////
	// parameter check
	generate
		if (PORT_W < 2 || PORT_W > 32) begin : g_bad_width
			$error("PORT_W must lie between 2 and 32");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// input synchronisers
	localparam int NS = PORT_W + 4;
	localparam int IX_A = 0;
	localparam int IX_B = 1;
	localparam int IX_GATE = 2;
	localparam int IX_TCLK = 3;

	logic [NS-1:0] async_in;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s3_q;
	logic [NS-1:0] lvl_q;

	assign async_in = {port_pins, timer_prescaled_clk, external_gate_pin,
		cmp_b_raw, cmp_a_raw};

	// a level counts only once the last two stages agree, filtering glitches
	genvar gs;
	generate
		for (gs = 0; gs < NS; gs++) begin : g_sync
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					s1_q[gs]  <= 1'b0;
					s2_q[gs]  <= 1'b0;
					s3_q[gs]  <= 1'b0;
					lvl_q[gs] <= 1'b0;
				end else if (ce) begin
					s1_q[gs] <= async_in[gs];
					s2_q[gs] <= s1_q[gs];
					s3_q[gs] <= s2_q[gs];
					if (s2_q[gs] == s3_q[gs]) begin
						lvl_q[gs] <= s3_q[gs];
					end
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// apb decode
	function automatic dcc_sel_t sel_of(input logic [`DCC_ADDR_W-1:0] a);
		case (a)
			`DCC_OFS_CMP_A:    sel_of = DCC_SEL_CMP_A;
			`DCC_OFS_CMP_B:    sel_of = DCC_SEL_CMP_B;
			`DCC_OFS_AUX:      sel_of = DCC_SEL_AUX;
			`DCC_OFS_IRQ_EN:   sel_of = DCC_SEL_IRQ_EN;
			`DCC_OFS_IRQ_FLAG: sel_of = DCC_SEL_IRQ_FLAG;
			`DCC_OFS_PORT:     sel_of = DCC_SEL_PORT;
			`DCC_OFS_ANALOG:   sel_of = DCC_SEL_ANALOG;
			`DCC_OFS_DIR:      sel_of = DCC_SEL_DIR;
			default:           sel_of = DCC_SEL_NONE;
		endcase
	endfunction : sel_of

	dcc_sel_t sel;
	logic     access;
	logic     wr;

	assign sel     = sel_of(paddr);
	// no wait states; a frozen block holds the access open
	assign pready  = ce;
	assign access  = psel && penable && ce;
	assign wr      = access && pwrite && (sel != DCC_SEL_NONE);
	assign pslverr = psel && penable && (sel == DCC_SEL_NONE);

	////////////////////////////////////////////////////////////////////////
	// control registers
	dcc_ctl_t             ctl_q [2];
	logic                 gss_q;
	logic                 sync_q;
	logic [3:0]           irq_en_q;
	logic [PORT_W-1:0]    analog_q;
	logic [PORT_W-1:0]    dir_q;

	// per-comparator control; result bit is not stored so writes skip it
	genvar gc;
	generate
		for (gc = 0; gc < 2; gc++) begin : g_ctl
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					ctl_q[gc] <= `DCC_RST_CTL;
				end else if (wr && sel == dcc_sel_t'(gc)) begin
					ctl_q[gc].enable         <= pwdata[`DCC_CTL_EN];
					ctl_q[gc].pin_drive      <= pwdata[`DCC_CTL_DRIVE];
					ctl_q[gc].invert         <= pwdata[`DCC_CTL_INVERT];
					ctl_q[gc].ref_select     <= pwdata[`DCC_CTL_REF];
					ctl_q[gc].channel_select <=
						pwdata[`DCC_CTL_CH_HI:`DCC_CTL_CH_LO];
				end
			end
		end
	endgenerate

	// auxiliary register: only gate source and sync bits are writable
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gss_q  <= `DCC_RST_GSS;
			sync_q <= `DCC_RST_SYNC;
		end else if (wr && sel == DCC_SEL_AUX) begin
			gss_q  <= pwdata[`DCC_AUX_GSS];
			sync_q <= pwdata[`DCC_AUX_SYNC];
		end
	end

	// interrupt enables, analog select and pin direction
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_en_q <= 4'h0;
			analog_q <= '0;
			dir_q    <= PORT_W'(`DCC_RST_DIR);
		end else if (wr) begin
			if (sel == DCC_SEL_IRQ_EN) begin
				irq_en_q <= pwdata[3:0];
			end
			if (sel == DCC_SEL_ANALOG) begin
				analog_q <= pwdata[PORT_W-1:0];
			end
			if (sel == DCC_SEL_DIR) begin
				dir_q <= pwdata[PORT_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// comparator results
	logic [1:0] raw_lvl;
	logic [1:0] result;

	assign raw_lvl = {lvl_q[IX_B], lvl_q[IX_A]};

	// a disabled comparator reads low; sleep does not touch this path
	genvar gr;
	generate
		for (gr = 0; gr < 2; gr++) begin : g_res
			assign result[gr] = ctl_q[gr].enable ?
				(raw_lvl[gr] ^ ctl_q[gr].invert) : 1'b0;
		end
	endgenerate

	// settings for the analog inputs
	assign cmp_a_analog = '{enable: ctl_q[0].enable,
		ref_select: ctl_q[0].ref_select,
		channel_select: ctl_q[0].channel_select};
	assign cmp_b_analog = '{enable: ctl_q[1].enable,
		ref_select: ctl_q[1].ref_select,
		channel_select: ctl_q[1].channel_select};

	////////////////////////////////////////////////////////////////////////
	// mismatch latches and interrupt flags
	logic [1:0] rd_latch_q;
	logic [1:0] cyc_latch_q;
	logic [1:0] mm_prev_q;
	logic [1:0] mismatch;
	logic [1:0] flag_q;

	assign mismatch = rd_latch_q ^ cyc_latch_q;

	// only control register accesses reload the read latch, never aux
	genvar gm;
	generate
		for (gm = 0; gm < 2; gm++) begin : g_mm
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					rd_latch_q[gm]  <= 1'b0;
					cyc_latch_q[gm] <= 1'b0;
					mm_prev_q[gm]   <= 1'b0;
				end else if (ce) begin
					cyc_latch_q[gm] <= result[gm];
					mm_prev_q[gm]   <= mismatch[gm];
					if (access && sel == dcc_sel_t'(gm)) begin
						rd_latch_q[gm] <= result[gm];
					end
				end
			end

			// a hardware set beats a software write in the same cycle
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					flag_q[gm] <= 1'b0;
				end else if (ce && mismatch[gm] && !mm_prev_q[gm]) begin
					flag_q[gm] <= 1'b1;
				end else if (wr && sel == DCC_SEL_IRQ_FLAG) begin
					flag_q[gm] <= pwdata[gm];
				end
			end
		end
	endgenerate

	// wake and vector requests to the core
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wake_req   <= 1'b0;
			irq_vector <= 1'b0;
		end else if (ce) begin
			wake_req   <= irq_en_q[`DCC_IE_PERIPH] &&
				|(flag_q & irq_en_q[`DCC_IE_B:`DCC_IE_A]);
			irq_vector <= irq_en_q[`DCC_IE_PERIPH] &&
				irq_en_q[`DCC_IE_GLOBAL] &&
				|(flag_q & irq_en_q[`DCC_IE_B:`DCC_IE_A]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timer gate path
	logic tclk_prev_q;
	logic capt_q;
	logic b_synced;

	// capture on the falling edge of the prescaled clock so the timer,
	// counting on the rising edge, never races the gate
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tclk_prev_q <= 1'b0;
			capt_q      <= 1'b0;
		end else if (ce) begin
			tclk_prev_q <= lvl_q[IX_TCLK];
			if (tclk_prev_q && !lvl_q[IX_TCLK]) begin
				capt_q <= result[1];
			end
		end
	end

	assign b_synced = sync_q ? capt_q : result[1];

	// timer qualifies this with its own on and gate-enable bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			timer_gate <= 1'b0;
		end else if (ce) begin
			timer_gate <= gss_q ? lvl_q[IX_GATE] : b_synced;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// comparator output pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmp_a_pin_out <= 1'b0;
			cmp_a_pin_oe  <= 1'b0;
			cmp_b_pin_out <= 1'b0;
			cmp_b_pin_oe  <= 1'b0;
		end else if (ce) begin
			cmp_a_pin_out <= result[0];
			cmp_b_pin_out <= result[1];
			cmp_a_pin_oe  <= ctl_q[0].pin_drive &&
				ctl_q[0].enable && !dir_q[0];
			cmp_b_pin_oe  <= ctl_q[1].pin_drive &&
				ctl_q[1].enable && !dir_q[1];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data, captured while selected so it stands in the access phase
	function automatic logic [31:0] ctl_word(input dcc_ctl_t c, input logic r);
		ctl_word = 32'h0;
		ctl_word[`DCC_CTL_EN]     = c.enable;
		ctl_word[`DCC_CTL_RESULT] = r;
		ctl_word[`DCC_CTL_DRIVE]  = c.pin_drive;
		ctl_word[`DCC_CTL_INVERT] = c.invert;
		ctl_word[`DCC_CTL_REF]    = c.ref_select;
		ctl_word[`DCC_CTL_CH_HI:`DCC_CTL_CH_LO] = c.channel_select;
	endfunction : ctl_word

	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h0;
		case (sel)
			DCC_SEL_CMP_A:    rdata_d = ctl_word(ctl_q[0], result[0]);
			DCC_SEL_CMP_B:    rdata_d = ctl_word(ctl_q[1], result[1]);
			DCC_SEL_AUX: begin
				rdata_d[`DCC_AUX_COPY_A] = result[0];
				rdata_d[`DCC_AUX_COPY_B] = result[1];
				rdata_d[`DCC_AUX_GSS]    = gss_q;
				rdata_d[`DCC_AUX_SYNC]   = sync_q;
			end
			DCC_SEL_IRQ_EN:   rdata_d[3:0] = irq_en_q;
			DCC_SEL_IRQ_FLAG: rdata_d[1:0] = flag_q;
			DCC_SEL_PORT:     rdata_d[PORT_W-1:0] =
				lvl_q[NS-1:4] & ~analog_q;
			DCC_SEL_ANALOG:   rdata_d[PORT_W-1:0] = analog_q;
			DCC_SEL_DIR:      rdata_d[PORT_W-1:0] = dir_q;
			default:          rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0;
		end else if (ce && psel && !pwrite) begin
			prdata <= rdata_d;
		end
	end

endmodule : dcc_top

// >>> dcc_cmp_model.sv
/* behavioural analog comparator standing beside dcc_top.
   assumes the bench sets input levels as plain high/low values. */
`timescale 1ns/1ps
module dcc_cmp_model
	import dcc_pkg::*;
(
	// settings and levels
	input  wire dcc_analog_t ana,
	input  wire logic        pos_pin,
	input  wire logic        ref_lvl,
	input  wire logic [3:0]  neg_pins,
	// result
	output logic             raw
);
	// high beats low only; no sleep input, so it runs while enabled
	always_comb begin
		raw = ana.enable & (ana.ref_select ? ref_lvl : pos_pin)
			& ~neg_pins[ana.channel_select];
	end
endmodule : dcc_cmp_model

// >>> dcc_top_sva.sv
/* assertions on the ports of dcc_top.
   assumes one clock and an apb master that keeps the contract. */
`timescale 1ns/1ps
module dcc_top_sva
	import dcc_pkg::*;
#(
	parameter int PORT_W = 8
) (
	// clock, reset, apb
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// watched outputs and the gate pin input
	input wire dcc_analog_t cmp_a_analog,
	input wire dcc_analog_t cmp_b_analog,
	input wire logic        cmp_a_pin_oe,
	input wire logic        cmp_b_pin_oe,
	input wire logic        external_gate_pin,
	input wire logic        timer_gate,
	input wire logic        wake_req,
	input wire logic        irq_vector
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic        take;
	logic        gss_q;
	logic [31:0] ana_q;
	logic [3:0]  wr_set;
	// settings as a write carries them: enable, ref, channel
	assign take = psel & penable & ce;
	assign wr_set = {pwdata[7], pwdata[2:0]};
	// shadow of the gate source bit, from taken writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gss_q <= 1'b1;
		end else if (take && pwrite && paddr == 12'h008) begin
			gss_q <= pwdata[1];
		end
	end
	// shadow of the analog select register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ana_q <= 32'h0;
		end else if (take && pwrite && paddr == 12'h018) begin
			ana_q <= pwdata;
		end
	end
	sequence s_wr(logic [11:0] a);
		take && pwrite && paddr == a;
	endsequence
	sequence s_rd(logic [11:0] a);
		take && !pwrite && paddr == a;
	endsequence
	//////////////////////////////
	chk_ctl_a_set: assert property (
		s_wr(12'h000) |=> cmp_a_analog == $past(wr_set))
		else $error("cmp a settings differ from write");
	chk_ctl_b_set: assert property (
		s_wr(12'h004) |=> cmp_b_analog == $past(wr_set))
		else $error("cmp b settings differ from write");
	chk_reset_off: assert property (disable iff (1'b0)
		!rstn ##1 !rstn |-> cmp_a_analog == 4'h0 && cmp_b_analog == 4'h0 && !wake_req)
		else $error("comparators on during reset");
	chk_pin_a_en: assert property (
		cmp_a_pin_oe && $stable(cmp_a_analog) |-> cmp_a_analog.enable)
		else $error("pin a driven while off");
	chk_pin_b_en: assert property (
		cmp_b_pin_oe && $stable(cmp_b_analog) |-> cmp_b_analog.enable)
		else $error("pin b driven while off");
	chk_vector_wake: assert property (irq_vector |-> wake_req)
		else $error("vector without wake");
	chk_gate_pin: assert property (
		(gss_q && $stable(external_gate_pin))[*6] |-> timer_gate == external_gate_pin)
		else $error("gate does not follow gate pin");
	chk_aux_zero: assert property (
		s_rd(12'h008) |-> prdata[5:2] == 4'h0 && prdata[31:8] == 24'h0)
		else $error("aux spare bits not zero");
	chk_ctl_zero: assert property (
		(s_rd(12'h000) or s_rd(12'h004)) |-> prdata[3] == 1'b0)
		else $error("ctl bit 3 not zero");
	chk_port_ana: assert property (
		s_rd(12'h014) |-> (prdata[PORT_W-1:0] & ana_q[PORT_W-1:0]) == '0)
		else $error("analog pin reads high");
endmodule : dcc_top_sva
bind dcc_top dcc_top_sva #(.PORT_W(PORT_W)) chk_u (
	.clk               (clk),
	.rstn              (rstn),
	.ce                (ce),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pwdata            (pwdata),
	.prdata            (prdata),
	.cmp_a_analog      (cmp_a_analog),
	.cmp_b_analog      (cmp_b_analog),
	.cmp_a_pin_oe      (cmp_a_pin_oe),
	.cmp_b_pin_oe      (cmp_b_pin_oe),
	.external_gate_pin (external_gate_pin),
	.timer_gate        (timer_gate),
	.wake_req          (wake_req),
	.irq_vector        (irq_vector)
);

// >>> tb_top.sv
/* directed bench for dcc_top with two comparator models.
   assumes ce held high, so every apb access has no wait state. */
`timescale 1ns/1ps
module tb_top
	import dcc_pkg::*;
;
	logic        clk, rstn, ce, psel, penable, pwrite, pready, pslverr, err;
	logic        cmp_b_pin_out, cmp_b_pin_oe;
	logic        tmr_run = 1'b1;
	int          tmr_cnt = 0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        cmp_a_raw, cmp_b_raw, cmp_a_pin_out, cmp_a_pin_oe;
	logic        timer_prescaled_clk, external_gate_pin, timer_gate;
	logic        wake_req, irq_vector, pos_a, pos_b, vref;
	logic [3:0]  negs;
	logic [7:0]  port_pins;
	dcc_analog_t cmp_a_analog, cmp_b_analog;
	int          fail_count = 0;
	int          checks = 0;
	int          cyc = 0;
	//////////////////////////////
	dcc_top dut_u (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .pslverr, .prdata, .cmp_a_raw, .cmp_b_raw, .cmp_a_analog,
		.cmp_b_analog, .cmp_a_pin_out, .cmp_a_pin_oe, .cmp_b_pin_out,
		.cmp_b_pin_oe, .timer_prescaled_clk, .external_gate_pin, .timer_gate,
		.port_pins, .wake_req, .irq_vector);
	dcc_cmp_model ma (.ana(cmp_a_analog), .pos_pin(pos_a), .ref_lvl(vref),
		.neg_pins(negs), .raw(cmp_a_raw));
	dcc_cmp_model mb (.ana(cmp_b_analog), .pos_pin(pos_b), .ref_lvl(vref),
		.neg_pins(negs), .raw(cmp_b_raw));
	// clock and a ceiling well above the directed run
	always #50 clk = ~clk;
	// far-side timer: counts on the rising edge while running and gated
	always @(posedge timer_prescaled_clk) begin
		if (tmr_run && timer_gate) begin
			tmr_cnt++;
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			results();
		end
	end
	//////////////////////////////
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so the next call never reassigns psel in this step
		@(posedge clk);
	endtask : apb
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		cmp(n, e, rd);
	endtask : rc
	task automatic results;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results
	//////////////////////////////
	initial begin
		{clk, rstn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
		{pos_a, pos_b, negs, timer_prescaled_clk, external_gate_pin} = '0;
		vref = 1'b1;
		port_pins = 8'h00;
		ce = 1'b1;
		wt(5);
		rstn <= 1'b1;
		@(posedge clk);
		rc(12'h000, 32'h0, "ctl a");
		rc(12'h004, 32'h0, "ctl b");
		rc(12'h008, 32'h2, "aux");
		// an unmapped word answers with an error and reads zero
		apb(1'b0, 12'h020, 32'h0);
		cmp("slverr", 32'h1, err);
		cmp("unmapped", 32'h0, rd);
		$display("reset test done");
		// read-only result bit and bit 3 ignored on write
		apb(1'b1, 12'h000, 32'hff);
		wt(6);
		rc(12'h000, 32'hb7, "ctl a inv");
		apb(1'b1, 12'h000, 32'hef);
		wt(6);
		rc(12'h000, 32'he7, "ctl a");
		// every channel and reference choice, two input patterns
		for (int p = 0; p < 2; p++) begin
			negs <= p ? 4'h3 : 4'h5;
			for (int s = 0; s < 8; s++) begin
				apb(1'b1, 12'h000, {24'h0, 5'h10, s[2:0]});
				wt(6);
				rc(12'h000, {24'h0, 1'b1, s[2] & ~negs[s[1:0]], 3'h0, s[2:0]}, "sel");
			end
		end
		negs <= 4'h0;
		$display("field test done");
		apb(1'b1, 12'h000, 32'h84);
		apb(1'b1, 12'h004, 32'h83);
		apb(1'b1, 12'h008, 32'hff);
		wt(6);
		rc(12'h008, 32'h83, "aux copy");
		pos_b <= 1'b1;
		wt(6);
		rc(12'h008, 32'hc3, "aux live");
		// drive needs drive bit, enable and an output direction
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 12'h01c, {31'h7f, i == 1});
			apb(1'b1, 12'h000, i == 2 ? 32'h84 : i == 3 ? 32'h24 : 32'ha4);
			wt(3);
			cmp("pin oe", i == 0, cmp_a_pin_oe);
			cmp("pin out", i != 3, cmp_a_pin_out);
		end
		cmp("pin out", 1'b0, cmp_a_pin_out);
		// comparator b drives its own pin once its direction bit is output
		apb(1'b1, 12'h01c, 32'hfc);
		apb(1'b1, 12'h004, 32'ha3);
		wt(3);
		cmp("pin b oe", 1'b1, cmp_b_pin_oe);
		cmp("pin b out", 1'b1, cmp_b_pin_out);
		port_pins <= 8'hff;
		apb(1'b1, 12'h018, 32'h0f);
		wt(6);
		rc(12'h014, 32'hf0, "port");
		$display("pin test done");
		apb(1'b1, 12'h000, 32'ha4);
		apb(1'b1, 12'h00c, 32'h5);
		// let the re-enabled result settle, then reload the read latch
		wt(2);
		rc(12'h000, 32'he4, "ctl a arm");
		apb(1'b1, 12'h010, 32'h0);
		negs <= 4'h1;
		wt(8);
		rc(12'h010, 32'h1, "flag");
		cmp("wake", 1'b1, wake_req);
		cmp("vector", 1'b0, irq_vector);
		apb(1'b1, 12'h00c, 32'hd);
		wt(2);
		cmp("vector", 1'b1, irq_vector);
		apb(1'b1, 12'h00c, 32'h1);
		wt(2);
		cmp("wake", 1'b0, wake_req);
		// an aux read must not reload the mismatch latch
		apb(1'b1, 12'h010, 32'h0);
		rc(12'h008, 32'h43, "aux");
		negs <= 4'h0;
		wt(8);
		rc(12'h010, 32'h0, "no flag");
		negs <= 4'h1;
		wt(8);
		apb(1'b1, 12'h000, 32'ha4);
		apb(1'b1, 12'h010, 32'h0);
		negs <= 4'h0;
		wt(8);
		rc(12'h010, 32'h1, "flag wr");
		$display("irq test done");
		apb(1'b1, 12'h008, 32'h2);
		pos_b <= 1'b0;
		external_gate_pin <= 1'b1;
		wt(8);
		cmp("gate pin", 1'b1, timer_gate);
		apb(1'b1, 12'h008, 32'h0);
		pos_b <= 1'b1;
		wt(8);
		cmp("gate cmp", 1'b1, timer_gate);
		// sync on whenever b gates the timer; prime the capture first
		apb(1'b1, 12'h008, 32'h1);
		// keep the first timer edge clear of the gate update
		wt(2);
		timer_prescaled_clk <= 1'b1;
		wt(4);
		timer_prescaled_clk <= 1'b0;
		wt(8);
		timer_prescaled_clk <= 1'b1;
		wt(4);
		pos_b <= 1'b0;
		wt(8);
		cmp("gate held", 1'b1, timer_gate);
		cmp("timer count", 32'h1, tmr_cnt);
		timer_prescaled_clk <= 1'b0;
		wt(8);
		cmp("gate cap", 1'b0, timer_gate);
		$display("gate test done");
		results();
	end
endmodule : tb_top
